// >>> hdl/rspc_consts.svh
// constants of the repeater strap and configuration front end
// assumes a single 125 MHz clock and four-level pads already resolved to 2-bit codes
`ifndef RSPC_CONSTS_SVH
`define RSPC_CONSTS_SVH

// ==========================================================
// timing
`define RSPC_CLK_MHZ        125
`define RSPC_STABLE_NS      1000
`define RSPC_STABLE_CYC     ((`RSPC_STABLE_NS * `RSPC_CLK_MHZ) / 1000)
`define RSPC_CNT_W          8

// ==========================================================
// channels, banks and strap pin slots
`define RSPC_NUM_CH         8
`define RSPC_BANK_CH        4
`define RSPC_CH_CFG_W       4
`define RSPC_NUM_STRAP      8
`define RSPC_PIN_BANK_A_DEEMPH_SEL      0
`define RSPC_PIN_DEMA1      1
`define RSPC_PIN_BANK_B_DEEMPH_SEL      2
`define RSPC_PIN_DEMB1      3
`define RSPC_PIN_RATE       4
`define RSPC_PIN_SDTH       5
`define RSPC_PIN_RX_DETECT_CTRL      6
`define RSPC_PIN_MGMT       7

// ==========================================================
// four-level pad codes
`define RSPC_LVL_PD_STRONG  2'h0
`define RSPC_LVL_PD_WEAK    2'h1
`define RSPC_LVL_FLOAT      2'h2
`define RSPC_LVL_PU_STRONG  2'h3
`define RSPC_RX_DETECT_CTRL_HIZ_LVL  2'h0

// ==========================================================
// register map and reset values
`define RSPC_ADDR_CH_CFG    12'h000
`define RSPC_ADDR_STATUS    12'h004
`define RSPC_ADDR_IRQ_STAT  12'h008
`define RSPC_ADDR_IRQ_MASK  12'h00c
`define RSPC_CH_CFG_RST     32'h00000000
`define RSPC_IRQ_MASK_RST   4'h0
`define RSPC_IRQ_W          4
`define RSPC_IRQ_MODE       0
`define RSPC_IRQ_RATE       1
`define RSPC_IRQ_CABLE      2
`define RSPC_IRQ_LOAD       3

`endif

// >>> hdl/rspc_pkg.sv
// types of the repeater strap and configuration front end
// assumes nothing beyond the constants header
package rspc_pkg;

   // ==========================================================
   // decoded settings and states
   typedef logic [1:0] rspc_lvl_type;
   typedef enum logic [1:0] {
      RSPC_RATE_GEN12,
      RSPC_RATE_AUTO,
      RSPC_RATE_GEN3_NODE,
      RSPC_RATE_GEN3_DE
   } rspc_rate_type;
   typedef enum logic [1:0] {
      RSPC_MODE_PIN,
      RSPC_MODE_EEPROM,
      RSPC_MODE_SLAVE
   } rspc_mode_type;
   typedef enum logic {
      RSPC_LOAD_IDLE,
      RSPC_LOAD_BUSY
   } rspc_load_type;

endpackage : rspc_pkg

// >>> hdl/rspc_strap_if.sv
// carrier between the top and the strap level filter
// assumes raw codes are synchronous to the shared clock
`timescale 1ns/1ps
`include "rspc_consts.svh"

interface rspc_strap_if;
   logic [`RSPC_NUM_STRAP-1:0][1:0] raw_lvl;
   logic [`RSPC_NUM_STRAP-1:0][1:0] dec_lvl;
   modport top (output raw_lvl, input dec_lvl);
   modport dec (input raw_lvl, output dec_lvl);
endinterface : rspc_strap_if

// >>> hdl/rspc_strap_decode.sv
// per-pin level filter for the four-level straps
// assumes codes arrive synchronous to clk; a level must hold a full window to be taken
`timescale 1ns/1ps
`include "rspc_consts.svh"

module rspc_strap_decode (
   input wire logic  clk,
   input wire logic  rst_b,
   rspc_strap_if.dec strap
);

   // ==========================================================
   // one filter per strap pin
   for (genvar i = 0; i < `RSPC_NUM_STRAP; i++) begin : g_pin
      rspc_pkg::rspc_lvl_type   lvl_q, lvl_d;
      rspc_pkg::rspc_lvl_type   cand_q, cand_d;
      logic [`RSPC_CNT_W-1:0]   cnt_q, cnt_d;

      // restart the window on any code change so glitches never reach the setting
      always_comb begin
         lvl_d  = lvl_q;
         cand_d = cand_q;
         cnt_d  = cnt_q;
         if (strap.raw_lvl[i] != cand_q) begin
            cand_d = strap.raw_lvl[i];
            cnt_d  = '0;
         end else if (cnt_q == `RSPC_CNT_W'(`RSPC_STABLE_CYC - 1)) begin
            lvl_d = cand_q;
         end else begin
            cnt_d = cnt_q + `RSPC_CNT_W'(1);
         end
      end

      always_ff @(posedge clk) begin
         if (!rst_b) begin
            lvl_q  <= `RSPC_LVL_PD_STRONG;
            cand_q <= `RSPC_LVL_PD_STRONG;
            cnt_q  <= '0;
         end else begin
            lvl_q  <= lvl_d;
            cand_q <= cand_d;
            cnt_q  <= cnt_d;
         end
      end

      assign strap.dec_lvl[i] = lvl_q;
   end

endmodule : rspc_strap_decode

// >>> hdl/rspc_top.sv
// configuration front end of an eight-channel serial-link repeater
// assumes pads resolve four-level straps to 2-bit codes and an outside loader/bus engine
//
// Summary of operation
// - pin mode: bank de-emphasis from its two pins, active in gen1/2 only
// - bank de-emphasis pins count as configuration only while mode pin is low
// - eight channels form banks A and B of four, set together
// - with mode pin high, per-channel settings come from registers
// - with mode pin high, bank A pins become clock/data, bank B address bits
// - rate pin: strong low gen1/2, float auto, weak low gen3, high gen3+de
// - signal detect threshold follows the decoded threshold pin level
// - rx detect pin picks low-ohm or high-impedance termination in every mode
// - cable absent high puts the device into low power
// - load result output high on failed eeprom load, low on success
// - mode pin high slave, floating eeprom master, low pin mode
// - eeprom load starts on a falling edge of the load trigger
`timescale 1ns/1ps
`include "rspc_consts.svh"

module rspc_top (
   input  wire logic                         clk,
   input  wire logic                         rst_b,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [11:0]                  paddr,
   input  wire logic [31:0]                  pwdata,
   output logic      [31:0]                  prdata,
   output logic                              pready,
   output logic                              pslverr,
   input  wire logic [1:0][1:0]              bank_a_deemph_sel,
   input  wire logic [1:0][1:0]              bank_b_deemph_sel,
   input  wire logic [1:0]                   mgmt_bus_mode_sel,
   input  wire logic [1:0]                   rate_sel,
   input  wire logic [1:0]                   sig_detect_threshold_sel,
   input  wire logic [1:0]                   rx_detect_ctrl,
   input  wire logic                         cable_absent,
   input  wire logic                         eeprom_load_trigger,
   input  wire logic                         eeprom_load_done,
   input  wire logic                         eeprom_load_ok,
   input  wire logic                         link_gen3_detected,
   output logic                              smb_scl_in,
   output logic                              smb_sda_in,
   output logic                              slave_addr_bit0,
   output logic                              slave_addr_bit1,
   output logic                              mgmt_slave_mode,
   output logic                              eeprom_load_start,
   output logic [`RSPC_NUM_CH*`RSPC_CH_CFG_W-1:0] ch_deemph,
   output logic [`RSPC_NUM_CH-1:0]           ch_deemph_en,
   output logic [1:0]                        rate_mode,
   output logic [1:0]                        sd_threshold,
   output logic                              rx_term_low_ohm,
   output logic                              low_power,
   output logic                              config_load_result,
   output logic                              irq
);

   // ==========================================================
   // strap level filter
   rspc_strap_if strap ();

   assign strap.raw_lvl = {mgmt_bus_mode_sel, rx_detect_ctrl, sig_detect_threshold_sel,
                           rate_sel, bank_b_deemph_sel, bank_a_deemph_sel};

   rspc_strap_decode u_dec (
      .clk   (clk),
      .rst_b (rst_b),
      .strap (strap)
   );

   // ==========================================================
   // mode and rate decode
   rspc_pkg::rspc_mode_type mode_q, mode_d;
   rspc_pkg::rspc_rate_type rate_q, rate_d;
   logic [1:0]              sdth_q, sdth_d;
   logic                    rxterm_q, rxterm_d;
   logic                    lowpwr_q, lowpwr_d;

   // weak pull-down on the mode pin has no meaning; treat it as pin mode
   always_comb begin
      case (strap.dec_lvl[`RSPC_PIN_MGMT])
         `RSPC_LVL_PU_STRONG: mode_d = rspc_pkg::RSPC_MODE_SLAVE;
         `RSPC_LVL_FLOAT:     mode_d = rspc_pkg::RSPC_MODE_EEPROM;
         default:             mode_d = rspc_pkg::RSPC_MODE_PIN;
      endcase
      case (strap.dec_lvl[`RSPC_PIN_RATE])
         `RSPC_LVL_PD_STRONG: rate_d = rspc_pkg::RSPC_RATE_GEN12;
         `RSPC_LVL_FLOAT:     rate_d = rspc_pkg::RSPC_RATE_AUTO;
         `RSPC_LVL_PD_WEAK:   rate_d = rspc_pkg::RSPC_RATE_GEN3_NODE;
         default:             rate_d = rspc_pkg::RSPC_RATE_GEN3_DE;
      endcase
      sdth_d   = strap.dec_lvl[`RSPC_PIN_SDTH];
      rxterm_d = strap.dec_lvl[`RSPC_PIN_RX_DETECT_CTRL] != `RSPC_RX_DETECT_CTRL_HIZ_LVL;
      lowpwr_d = cable_absent;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         mode_q   <= rspc_pkg::RSPC_MODE_PIN;
         rate_q   <= rspc_pkg::RSPC_RATE_GEN12;
         sdth_q   <= `RSPC_LVL_PD_STRONG;
         rxterm_q <= 1'b0;
         lowpwr_q <= 1'b0;
      end else begin
         mode_q   <= mode_d;
         rate_q   <= rate_d;
         sdth_q   <= sdth_d;
         rxterm_q <= rxterm_d;
         lowpwr_q <= lowpwr_d;
      end
   end

   // ==========================================================
   // per-channel de-emphasis source
   logic [`RSPC_CH_CFG_W-1:0]                bank_a_cfg;
   logic [`RSPC_CH_CFG_W-1:0]                bank_b_cfg;
   logic [`RSPC_NUM_CH*`RSPC_CH_CFG_W-1:0]   ch_cfg_q, ch_cfg_d;
   logic [`RSPC_NUM_CH*`RSPC_CH_CFG_W-1:0]   ch_src;
   logic [`RSPC_NUM_CH*`RSPC_CH_CFG_W-1:0]   deemph_q, deemph_d;
   logic [`RSPC_NUM_CH-1:0]                  deemph_en_q, deemph_en_d;
   logic                                     pin_mode;

   assign pin_mode   = mode_d == rspc_pkg::RSPC_MODE_PIN;
   assign bank_a_cfg = {strap.dec_lvl[`RSPC_PIN_DEMA1], strap.dec_lvl[`RSPC_PIN_BANK_A_DEEMPH_SEL]};
   assign bank_b_cfg = {strap.dec_lvl[`RSPC_PIN_DEMB1], strap.dec_lvl[`RSPC_PIN_BANK_B_DEEMPH_SEL]};

   // pins only in pin mode, else each channel from its own register nibble
   for (genvar c = 0; c < `RSPC_NUM_CH; c++) begin : g_ch
      assign ch_src[c*`RSPC_CH_CFG_W +: `RSPC_CH_CFG_W] =
         !pin_mode ? ch_cfg_q[c*`RSPC_CH_CFG_W +: `RSPC_CH_CFG_W] :
         (c < `RSPC_BANK_CH) ? bank_a_cfg : bank_b_cfg;
   end

   // de-emphasis only acts at gen1/2 rates; auto follows the detected rate
   always_comb begin
      deemph_d    = ch_src;
      deemph_en_d = {`RSPC_NUM_CH{(rate_d == rspc_pkg::RSPC_RATE_GEN12) ||
                    ((rate_d == rspc_pkg::RSPC_RATE_AUTO) && !link_gen3_detected)}};
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         deemph_q    <= '0;
         deemph_en_q <= '0;
      end else begin
         deemph_q    <= deemph_d;
         deemph_en_q <= deemph_en_d;
      end
   end

   // ==========================================================
   // management bus pin reuse
   logic scl_q, scl_d, sda_q, sda_d, ad0_q, ad0_d, ad1_q, ad1_d;

   // high half of the pad code reads as a logic one on two-level use
   always_comb begin
      scl_d = !pin_mode && strap.raw_lvl[`RSPC_PIN_BANK_A_DEEMPH_SEL][1];
      sda_d = !pin_mode && strap.raw_lvl[`RSPC_PIN_DEMA1][1];
      ad0_d = !pin_mode && strap.raw_lvl[`RSPC_PIN_BANK_B_DEEMPH_SEL][1];
      ad1_d = !pin_mode && strap.raw_lvl[`RSPC_PIN_DEMB1][1];
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         scl_q <= 1'b0;
         sda_q <= 1'b0;
         ad0_q <= 1'b0;
         ad1_q <= 1'b0;
      end else begin
         scl_q <= scl_d;
         sda_q <= sda_d;
         ad0_q <= ad0_d;
         ad1_q <= ad1_d;
      end
   end

   // ==========================================================
   // eeprom load sequencing
   rspc_pkg::rspc_load_type load_q, load_d;
   logic                    trig_q;
   logic                    start_q, start_d;
   logic                    result_q, result_d;
   logic                    load_ev;

   // triggers during a load are ignored; the loader owns the bus until done
   always_comb begin
      load_d   = load_q;
      start_d  = 1'b0;
      result_d = result_q;
      load_ev  = 1'b0;
      case (load_q)
         rspc_pkg::RSPC_LOAD_IDLE: begin
            if (mode_q == rspc_pkg::RSPC_MODE_EEPROM && trig_q && !eeprom_load_trigger) begin
               start_d = 1'b1;
               load_d  = rspc_pkg::RSPC_LOAD_BUSY;
            end
         end
         default: begin
            if (eeprom_load_done) begin
               result_d = !eeprom_load_ok;
               load_ev  = 1'b1;
               load_d   = rspc_pkg::RSPC_LOAD_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         load_q   <= rspc_pkg::RSPC_LOAD_IDLE;
         trig_q   <= 1'b0;
         start_q  <= 1'b0;
         result_q <= 1'b0;
      end else begin
         load_q   <= load_d;
         trig_q   <= eeprom_load_trigger;
         start_q  <= start_d;
         result_q <= result_d;
      end
   end

   // ==========================================================
   // apb register slave and interrupt
   logic [`RSPC_IRQ_W-1:0] stat_q, stat_d, mask_q, mask_d, ev;
   logic [31:0]            prdata_q, prdata_d, status_w;
   logic                   wr_acc, rd_acc, setup, hit;

   assign setup  = psel && !penable;
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;
   assign hit    = paddr == `RSPC_ADDR_CH_CFG || paddr == `RSPC_ADDR_STATUS ||
                   paddr == `RSPC_ADDR_IRQ_STAT || paddr == `RSPC_ADDR_IRQ_MASK;
   assign status_w = {22'h000000, load_q == rspc_pkg::RSPC_LOAD_BUSY, result_q, lowpwr_q,
                      mode_q, rxterm_q, sdth_q, rate_q};

   // event sets win over the clearing read in the same cycle
   always_comb begin
      ev                  = '0;
      ev[`RSPC_IRQ_MODE]  = mode_d != mode_q;
      ev[`RSPC_IRQ_RATE]  = rate_d != rate_q;
      ev[`RSPC_IRQ_CABLE] = lowpwr_d != lowpwr_q;
      ev[`RSPC_IRQ_LOAD]  = load_ev;
      stat_d   = stat_q;
      mask_d   = mask_q;
      ch_cfg_d = ch_cfg_q;
      prdata_d = prdata_q;
      if (rd_acc && paddr == `RSPC_ADDR_IRQ_STAT) begin
         stat_d = '0;
      end
      stat_d = stat_d | ev;
      if (wr_acc && paddr == `RSPC_ADDR_CH_CFG) begin
         ch_cfg_d = pwdata;
      end else if (wr_acc && paddr == `RSPC_ADDR_IRQ_MASK) begin
         mask_d = pwdata[`RSPC_IRQ_W-1:0];
      end
      if (setup && paddr == `RSPC_ADDR_CH_CFG) begin
         prdata_d = ch_cfg_q;
      end else if (setup && paddr == `RSPC_ADDR_STATUS) begin
         prdata_d = status_w;
      end else if (setup && paddr == `RSPC_ADDR_IRQ_STAT) begin
         prdata_d = {28'h0000000, stat_q};
      end else if (setup && paddr == `RSPC_ADDR_IRQ_MASK) begin
         prdata_d = {28'h0000000, mask_q};
      end else if (setup) begin
         prdata_d = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         stat_q   <= '0;
         mask_q   <= `RSPC_IRQ_MASK_RST;
         ch_cfg_q <= `RSPC_CH_CFG_RST;
         prdata_q <= '0;
      end else begin
         stat_q   <= stat_d;
         mask_q   <= mask_d;
         ch_cfg_q <= ch_cfg_d;
         prdata_q <= prdata_d;
      end
   end

   // ==========================================================
   // outputs
   assign prdata             = prdata_q;
   assign pready             = 1'b1;
   assign pslverr            = psel && penable && !hit;
   assign irq                = |(stat_q & mask_q);
   assign smb_scl_in         = scl_q;
   assign smb_sda_in         = sda_q;
   assign slave_addr_bit0    = ad0_q;
   assign slave_addr_bit1    = ad1_q;
   assign mgmt_slave_mode    = mode_q == rspc_pkg::RSPC_MODE_SLAVE;
   assign eeprom_load_start  = start_q;
   assign ch_deemph          = deemph_q;
   assign ch_deemph_en       = deemph_en_q;
   assign rate_mode          = rate_q;
   assign sd_threshold       = sdth_q;
   assign rx_term_low_ohm    = rxterm_q;
   assign low_power          = lowpwr_q;
   assign config_load_result = result_q;

   // ==========================================================
   // assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   property p_bank_a;
      (strap.dec_lvl[`RSPC_PIN_MGMT] == `RSPC_LVL_PD_STRONG)
         |=> ch_deemph[15:0] == {4{$past(bank_a_cfg)}};
   endproperty
   a_bank_a: assert property (p_bank_a) else $error("bank a channels differ from pins");

   property p_gen3_no_deemph;
      (strap.dec_lvl[`RSPC_PIN_RATE] == `RSPC_LVL_PU_STRONG) |=> ch_deemph_en == '0;
   endproperty
   a_gen3_no_deemph: assert property (p_gen3_no_deemph) else $error("de-emph on at gen3");

   property p_reg_mode;
      (mode_d != rspc_pkg::RSPC_MODE_PIN) |=> ch_deemph == $past(ch_cfg_q);
   endproperty
   a_reg_mode: assert property (p_reg_mode) else $error("pins used outside pin mode");

   property p_reg_write;
      (wr_acc && paddr == `RSPC_ADDR_CH_CFG && mode_d == rspc_pkg::RSPC_MODE_SLAVE &&
       !$changed(strap.dec_lvl[`RSPC_PIN_MGMT])) ##1 (mode_d == rspc_pkg::RSPC_MODE_SLAVE)
         |=> ch_deemph == $past(pwdata, 2);
   endproperty
   a_reg_write: assert property (p_reg_write) else $error("register write not applied");

   property p_addr_reuse;
      (mode_d == rspc_pkg::RSPC_MODE_SLAVE) |=>
         slave_addr_bit1 == $past(bank_b_deemph_sel[1][1]) &&
         smb_scl_in == $past(bank_a_deemph_sel[0][1]);
   endproperty
   a_addr_reuse: assert property (p_addr_reuse) else $error("bus pin reuse wrong");

   property p_rate_weak;
      (strap.dec_lvl[`RSPC_PIN_RATE] == `RSPC_LVL_PD_WEAK)
         |=> rate_mode == rspc_pkg::RSPC_RATE_GEN3_NODE;
   endproperty
   a_rate_weak: assert property (p_rate_weak) else $error("weak pull-down rate wrong");

   property p_sdth;
      ##1 sd_threshold == $past(strap.dec_lvl[`RSPC_PIN_SDTH]);
   endproperty
   a_sdth: assert property (p_sdth) else $error("threshold not following pin");

   property p_rxterm;
      (strap.dec_lvl[`RSPC_PIN_RX_DETECT_CTRL] == `RSPC_RX_DETECT_CTRL_HIZ_LVL) |=> !rx_term_low_ohm;
   endproperty
   a_rxterm: assert property (p_rxterm) else $error("termination not high impedance");

   property p_lowpwr;
      cable_absent [*2] |-> low_power;
   endproperty
   a_lowpwr: assert property (p_lowpwr) else $error("no low power without cable");

   property p_load_fail;
      (load_q == rspc_pkg::RSPC_LOAD_BUSY && eeprom_load_done && !eeprom_load_ok)
         |=> config_load_result && !eeprom_load_start;
   endproperty
   a_load_fail: assert property (p_load_fail) else $error("failed load not reported");

   property p_float_mode;
      (strap.dec_lvl[`RSPC_PIN_MGMT] == `RSPC_LVL_FLOAT)
         |=> mode_q == rspc_pkg::RSPC_MODE_EEPROM && !mgmt_slave_mode;
   endproperty
   a_float_mode: assert property (p_float_mode) else $error("floating mode pin wrong");

   property p_load_start;
      (mode_q == rspc_pkg::RSPC_MODE_EEPROM && load_q == rspc_pkg::RSPC_LOAD_IDLE &&
       $fell(eeprom_load_trigger)) |=> eeprom_load_start ##1 !eeprom_load_start;
   endproperty
   a_load_start: assert property (p_load_start) else $error("load not started");

   property p_stable;
      $changed(strap.dec_lvl[`RSPC_PIN_RATE])
         |-> $past(rate_sel) == strap.dec_lvl[`RSPC_PIN_RATE];
   endproperty
   a_stable: assert property (p_stable) else $error("strap taken while unstable");

   c_slave: cover property (mode_q == rspc_pkg::RSPC_MODE_SLAVE ##1 wr_acc);
   c_load: cover property (eeprom_load_start ##[1:50] config_load_result);
   c_irq: cover property ($rose(irq));

endmodule : rspc_top

// >>> verification/rspc_eeprom_model.sv
// behavioural external eeprom loader answering the load start pulse
// assumes the bench owns the trigger pin and picks pass or fail per load
`timescale 1ns/1ps

module rspc_eeprom_model #(
   parameter int LOAD_CYC = 20
) (
   input  wire logic clk,
   input  wire logic eeprom_load_start,
   input  wire logic fail,
   output logic      eeprom_load_done = 1'b0,
   output logic      eeprom_load_ok = 1'b0
);
   int cnt = 0;

   // ==========================================================
   // load engine
   // done comes a fixed time after start; ok toggles outside done so
   // a stale pass level can never be mistaken for a real one
   always @(posedge clk) begin
      if (eeprom_load_start) cnt <= LOAD_CYC;
      else if (cnt > 0) cnt <= cnt - 1;
      eeprom_load_done <= (cnt == 1);
      eeprom_load_ok   <= (cnt == 1) ? ~fail : ~eeprom_load_ok;
   end
endmodule : rspc_eeprom_model

// >>> verification/tb.sv
// self-checking bench of the strap and configuration front end
// assumes the 125-cycle strap filter and zero-wait apb of the design
`timescale 1ns/1ps
`include "rspc_consts.svh"

module tb;
   logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, ch_deemph, rd;
   logic [1:0][1:0] ba = 0, bb = 0;
   logic [1:0] mode = 0, rate = 0, sdth = 0, rxd = 0, rate_mode, sd_thr;
   logic cab = 0, trig = 0, gen3 = 0, done, ok, fail = 0, scl, sda, ad0, ad1, slv, start;
   logic rx_lo, low_power, result, irq, err;
   logic [7:0] en;
   int fail_count = 0, n_tests = 0;

   // ==========================================================
   // clock and design
   initial forever #4 clk = ~clk;
   rspc_top dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .bank_a_deemph_sel(ba), .bank_b_deemph_sel(bb), .mgmt_bus_mode_sel(mode),
      .rate_sel(rate), .sig_detect_threshold_sel(sdth), .rx_detect_ctrl(rxd),
      .cable_absent(cab), .eeprom_load_trigger(trig), .eeprom_load_done(done),
      .eeprom_load_ok(ok), .link_gen3_detected(gen3), .smb_scl_in(scl), .smb_sda_in(sda),
      .slave_addr_bit0(ad0), .slave_addr_bit1(ad1), .mgmt_slave_mode(slv),
      .eeprom_load_start(start), .ch_deemph(ch_deemph), .ch_deemph_en(en),
      .rate_mode(rate_mode), .sd_threshold(sd_thr), .rx_term_low_ohm(rx_lo),
      .low_power(low_power), .config_load_result(result), .irq(irq));
   rspc_eeprom_model mdl (.clk(clk), .eeprom_load_start(start), .fail(fail),
      .eeprom_load_done(done), .eeprom_load_ok(ok));

   // ==========================================================
   // shared tasks
   task summarize;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : summarize
   task chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
         fail_count++;
      end
   endtask : chk
   // one transfer; waits for pready under a bound
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (i == 50) begin fail_count++; summarize(); end
      rd = prdata; err = pslverr;
      psel <= 0; penable <= 0;
   endtask : apb
   task settle; // filter window plus output register
      repeat (130) @(posedge clk);
   endtask : settle
   task automatic wait_hi(ref logic s);
      int i;
      for (i = 0; i < 300 && s !== 1'b1; i++) @(posedge clk);
      if (s !== 1'b1) begin fail_count++; summarize(); end
   endtask : wait_hi

   // ==========================================================
   // scenarios
   task s_pin; // bank straps and every rate code
      logic [1:0] lv [4];
      lv = '{2'h0, 2'h2, 2'h1, 2'h3};
      @(posedge clk);
      ba <= {2'h3, 2'h1}; bb <= {2'h0, 2'h2}; sdth <= 2'h1; rxd <= 2'h0;
      settle();
      chk(ch_deemph, 32'h2222dddd);
      chk(sd_thr, 2'h1);
      chk(rx_lo, 1'b0);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         rate <= lv[i];
         settle();
         chk(rate_mode, i);
         chk(en, i < 2 ? 8'hff : 8'h00);
         // auto rate: a detected gen3 link must drop de-emphasis
         if (i == 1) begin
            gen3 <= 1;
            repeat (2) @(posedge clk);
            chk(en, 8'h00);
            gen3 <= 0;
         end
      end
      @(posedge clk);
      rate <= 2'h0; rxd <= 2'h2; sdth <= 2'h3;
      repeat (60) @(posedge clk);
      chk(sd_thr, 2'h1);
      settle();
      chk({sd_thr, rx_lo}, 3'h7);
   endtask : s_pin
   task s_irq; // cable event, mask, read clear, unmapped place
      apb(0, `RSPC_ADDR_IRQ_STAT, 0);
      apb(1, `RSPC_ADDR_IRQ_MASK, 32'h4);
      cab <= 1;
      repeat (3) @(posedge clk);
      chk({low_power, irq}, 2'h3);
      apb(0, `RSPC_ADDR_IRQ_STAT, 0);
      chk(rd, 32'h4);
      @(posedge clk);
      chk(irq, 1'b0);
      apb(0, 12'h010, 0);
      chk({err, rd}, 33'h100000000);
      cab <= 0;
   endtask : s_irq
   task s_slave; // bus mode: pins reused, channels set by register
      @(posedge clk);
      mode <= 2'h3;
      settle();
      chk(slv, 1'b1);
      chk({scl, sda, ad0, ad1}, 4'h6);
      apb(1, `RSPC_ADDR_CH_CFG, 32'h87654321);
      repeat (2) @(posedge clk);
      chk(ch_deemph, 32'h87654321);
      ba <= {2'h0, 2'h3}; rxd <= 2'h0;
      settle();
      chk({ch_deemph, scl}, 33'h10eca8643);
      chk(rx_lo, 1'b0);
   endtask : s_slave
   task s_eeprom; // failed then passed load
      @(posedge clk);
      mode <= 2'h2;
      settle();
      for (int k = 0; k < 2; k++) begin
         fail <= (k == 0); trig <= 1;
         @(posedge clk);
         trig <= 0;
         wait_hi(start);
         wait_hi(done);
         repeat (2) @(posedge clk);
         chk(result, k == 0);
      end
      // eeprom mode, pass result, threshold 3 seen in status
      apb(0, `RSPC_ADDR_STATUS, 0);
      chk(rd, 32'h2c);
      // load done, cable and mode change events since the last clear
      apb(0, `RSPC_ADDR_IRQ_STAT, 0);
      chk(rd, 32'hd);
   endtask : s_eeprom

   initial begin
      repeat (12) @(posedge clk);
      rst_b <= 1;
      @(posedge clk);
      chk({rate_mode, low_power, irq, result, pready}, 6'h1);
      s_pin();
      s_irq();
      s_slave();
      s_eeprom();
      summarize();
   end
endmodule : tb
